/* File: conv_ctrl_map.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef CONV_CTRL_MAP_SVH
`define CONV_CTRL_MAP_SVH

`define ADDR_CHANNEL_CONTROL_STATUS 4'h0
`define ADDR_TRIGGER_COMPARE_CONTROL 4'h1
`define ADDR_RESULT_HIGH 4'h2
`define ADDR_RESULT_LOW 4'h3
`define ADDR_CONVERSION_CONFIG 4'h4
`define ADDR_COMPARE_VALUE_HIGH 4'h5
`define ADDR_COMPARE_VALUE_LOW 4'h6
`define ADDR_PIN_CONTROL_ONE 4'h7
`define ADDR_PIN_CONTROL_TWO 4'h8

`define CCS_COMPLETE_BIT 7
`define CCS_IRQ_EN_BIT 6
`define CCS_CONT_BIT 5
`define TCC_ACTIVE_BIT 7
`define TCC_HW_TRIG_BIT 6
`define TCC_CMP_EN_BIT 5
`define TCC_CMP_GT_BIT 4
`define CFG_LONG_SAMPLE_BIT 4

`define CCS_RESET 8'h1f
`define TCC_RESET 8'h00
`define CFG_RESET 8'h00

`define SAMPLE_SHORT_HALF 6'h07
`define SAMPLE_LONG_HALF 6'h2f
`define CONVERT_CYCLES 5'h0a
`define RES_TEN_BIT 2'h2
`define CLK_ASYNC 2'h3
`define CHANNEL_IDLE 5'h1f

`endif

/* File: conv_ctrl_pkg.sv */
// Types shared by the converter control logic.
package conv_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b11
    } conv_state_t;
endpackage : conv_ctrl_pkg

/* File: adc_lowpower_and_control.sv */
// Converter control: registers, stop-mode handling and conversion sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "conv_ctrl_map.svh"

// Contract
// - Without async clock, stop3 entry aborts conversion and returns to idle.
// - Stop3 entry or exit never changes the result registers; conversions completed during stop3 do.
// - After an aborted stop3, stay idle until a new trigger arrives.
// - With async clock selected, conversion continues through stop3 to completion.
// - In stop3 with async clock, hardware trigger or continuous mode starts conversions.
// - Completion in stop3 sets complete flag and interrupt if enabled, waking.
// - Stop2 disables converter; all registers return to reset values.
// - Config: low power 7, divider 6:5, long sample 4, resolution 3:2, clock 1:0.
// - Control 2: active flag 7, hw trigger 6, compare enable 5, greater 4.
// - Control 2 bits 3:2 read zero; bits 1:0 reserved, written zero.
// - Control 1: complete flag 7, irq enable 6, continuous 5, channel 4:0.
// - After high result read, results stay until low byte read.
// - Input at or above high reference gives full scale; at or below low, zero.
// - Sample window 3.5 conversion clocks short, 23.5 long; the code rounds up to 4 and 24.
// - Pin-control bit disables digital I/O; conversions work without it.
// - Compare: flag and result update only when condition met.
module adc_lowpower_and_control
    import conv_ctrl_pkg::*;
#(
    parameter int RES_W = 10,
    parameter int PIN_N = 16
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic stop3_mode,
    input wire logic stop2_mode,
    input wire logic hw_trigger,
    input wire logic [RES_W-1:0] analog_sample,
    input wire logic at_ref_high,
    input wire logic at_ref_low,
    output logic conv_irq,
    output logic [PIN_N-1:0] pin_digital_disable,
    output logic [4:0] sampled_channel
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] conversion_config;
    logic [6:0] tcc_bits;
    logic [6:0] ccs_bits;
    logic conv_complete_flag;
    logic [1:0] compare_value_high;
    logic [7:0] compare_value_low;
    logic [7:0] pin_control_one;
    logic [7:0] pin_control_two;
    logic [RES_W-1:0] result;
    logic high_read_lock;
    conv_state_t state;
    logic [5:0] half_count;
    logic [4:0] conv_count;
    logic stop3_prev;
    logic [1:0] div_count;

    logic soft_reset;
    logic wr_ccs;
    logic wr_cfg;
    logic wr_tcc;
    logic wr_cvh;
    logic wr_cvl;
    logic wr_pc1;
    logic wr_pc2;
    logic async_sel;
    logic conv_tick;
    logic start_req;
    logic abort;
    logic done;
    logic [RES_W-1:0] raw_code;
    logic [RES_W-1:0] cmp_value;
    logic [RES_W:0] diff;
    logic cmp_pass;
    logic [RES_W-1:0] full_scale;
    logic [5:0] sample_half;
    logic stop3_entry;

    assign soft_reset = stop2_mode;
    assign wr_ccs = reg_write && reg_addr == `ADDR_CHANNEL_CONTROL_STATUS;
    assign wr_cfg = reg_write && reg_addr == `ADDR_CONVERSION_CONFIG;
    assign wr_tcc = reg_write && reg_addr == `ADDR_TRIGGER_COMPARE_CONTROL;
    assign wr_cvh = reg_write && reg_addr == `ADDR_COMPARE_VALUE_HIGH;
    assign wr_cvl = reg_write && reg_addr == `ADDR_COMPARE_VALUE_LOW;
    assign wr_pc1 = reg_write && reg_addr == `ADDR_PIN_CONTROL_ONE;
    assign wr_pc2 = reg_write && reg_addr == `ADDR_PIN_CONTROL_TWO;
    assign async_sel = conversion_config[1:0] == `CLK_ASYNC;
    assign stop3_entry = stop3_mode && !stop3_prev;
    // Without the async clock every conversion clock stops in stop3.
    assign abort = stop3_entry && !async_sel && state != ST_IDLE;

    // ------------------------------------------------------------------
    // Conversion clock divider
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_count <= 2'h0;
        end else if (soft_reset || state == ST_IDLE) begin
            div_count <= 2'h0;
        end else begin
            div_count <= div_count + 2'h1;
        end
    end

    always_comb begin
        unique case (conversion_config[6:5])
            2'b00: conv_tick = 1'b1;
            2'b01: conv_tick = div_count[0];
            2'b10, 2'b11: conv_tick = &div_count;
        endcase
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            conversion_config <= `CFG_RESET;
        end else if (soft_reset) begin
            conversion_config <= `CFG_RESET;
        end else if (wr_cfg) begin
            conversion_config <= reg_wdata;
        end
    end

    // Bits 3:0 are held at zero whatever is written.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tcc_bits <= 7'(`TCC_RESET);
        end else if (soft_reset) begin
            tcc_bits <= 7'(`TCC_RESET);
        end else if (wr_tcc) begin
            tcc_bits <= {reg_wdata[6:4], 4'h0};
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ccs_bits <= 7'(`CCS_RESET);
        end else if (soft_reset) begin
            ccs_bits <= 7'(`CCS_RESET);
        end else if (wr_ccs) begin
            ccs_bits <= reg_wdata[6:0];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            compare_value_high <= 2'h0;
            compare_value_low <= 8'h00;
        end else if (soft_reset) begin
            compare_value_high <= 2'h0;
            compare_value_low <= 8'h00;
        end else if (wr_cvh) begin
            compare_value_high <= reg_wdata[1:0];
        end else if (wr_cvl) begin
            compare_value_low <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_control_one <= 8'h00;
            pin_control_two <= 8'h00;
        end else if (soft_reset) begin
            pin_control_one <= 8'h00;
            pin_control_two <= 8'h00;
        end else if (wr_pc1) begin
            pin_control_one <= reg_wdata;
        end else if (wr_pc2) begin
            pin_control_two <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Trigger and sequencer
    // ------------------------------------------------------------------
    always_comb begin
        if (tcc_bits[6]) begin
            start_req = hw_trigger;
        end else begin
            start_req = wr_ccs && reg_wdata[4:0] != `CHANNEL_IDLE;
        end
    end

    assign sample_half = conversion_config[`CFG_LONG_SAMPLE_BIT]
        ? `SAMPLE_LONG_HALF : `SAMPLE_SHORT_HALF;
    assign done = state == ST_CONVERT && conv_tick
        && conv_count == `CONVERT_CYCLES - 5'h1;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stop3_prev <= 1'b0;
        end else begin
            stop3_prev <= stop3_mode;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            half_count <= 6'h00;
            conv_count <= 5'h00;
        end else if (soft_reset || abort) begin
            state <= ST_IDLE;
            half_count <= 6'h00;
            conv_count <= 5'h00;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    // Only a fresh trigger leaves idle after an abort.
                    if (start_req && (!stop3_mode || async_sel)) begin
                        state <= ST_SAMPLE;
                        half_count <= 6'h00;
                    end
                end
                ST_SAMPLE: begin
                    // Each tick adds two half cycles, so the window rounds up.
                    if (conv_tick) begin
                        half_count <= half_count + 6'h2;
                        if (half_count + 6'h2 >= sample_half) begin
                            state <= ST_CONVERT;
                            conv_count <= 5'h00;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (conv_tick) begin
                        conv_count <= conv_count + 5'h1;
                        if (done) begin
                            // Conversion runs on in stop3 with async clock.
                            if (ccs_bits[5] && ccs_bits[4:0] != `CHANNEL_IDLE) begin
                                state <= ST_SAMPLE;
                                half_count <= 6'h00;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Result, saturation and compare
    // ------------------------------------------------------------------
    assign full_scale = conversion_config[3:2] == `RES_TEN_BIT
        ? {RES_W{1'b1}} : RES_W'(8'hff);

    always_comb begin
        if (at_ref_high) begin
            raw_code = full_scale;
        end else if (at_ref_low) begin
            raw_code = '0;
        end else if (conversion_config[3:2] == `RES_TEN_BIT) begin
            raw_code = analog_sample;
        end else begin
            raw_code = RES_W'(analog_sample[RES_W-1:RES_W-8]);
        end
    end

    assign cmp_value = {compare_value_high, compare_value_low};
    assign diff = {1'b0, raw_code} - {1'b0, cmp_value};
    always_comb begin
        if (!tcc_bits[5]) begin
            cmp_pass = 1'b1;
        end else if (tcc_bits[4]) begin
            cmp_pass = !diff[RES_W];
        end else begin
            cmp_pass = diff[RES_W];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            result <= '0;
        end else if (soft_reset) begin
            result <= '0;
        end else if (done && cmp_pass && !high_read_lock
                && !abort) begin
            result <= tcc_bits[5] ? diff[RES_W-1:0] : raw_code;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            high_read_lock <= 1'b0;
        end else if (soft_reset) begin
            high_read_lock <= 1'b0;
        end else if (reg_read && reg_addr == `ADDR_RESULT_HIGH) begin
            high_read_lock <= 1'b1;
        end else if (reg_read && reg_addr == `ADDR_RESULT_LOW) begin
            high_read_lock <= 1'b0;
        end
    end

    // Completion is set on a good result; a write to control 1 clears it.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            conv_complete_flag <= 1'b0;
        end else if (soft_reset) begin
            conv_complete_flag <= 1'b0;
        end else if (done && cmp_pass && !abort) begin
            conv_complete_flag <= 1'b1;
        end else if (wr_ccs) begin
            conv_complete_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read port and outputs
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            unique case (reg_addr)
                `ADDR_CHANNEL_CONTROL_STATUS:
                    reg_rdata <= {conv_complete_flag, ccs_bits};
                `ADDR_TRIGGER_COMPARE_CONTROL:
                    reg_rdata <= {state != ST_IDLE, tcc_bits};
                `ADDR_RESULT_HIGH: reg_rdata <= 8'(result >> 8);
                `ADDR_RESULT_LOW: reg_rdata <= result[7:0];
                `ADDR_CONVERSION_CONFIG: reg_rdata <= conversion_config;
                `ADDR_COMPARE_VALUE_HIGH: reg_rdata <= {6'h00, compare_value_high};
                `ADDR_COMPARE_VALUE_LOW: reg_rdata <= compare_value_low;
                `ADDR_PIN_CONTROL_ONE: reg_rdata <= pin_control_one;
                `ADDR_PIN_CONTROL_TWO: reg_rdata <= pin_control_two;
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    assign conv_irq = conv_complete_flag && ccs_bits[6];
    // Conversion does not depend on these bits.
    assign pin_digital_disable =
        PIN_N'({pin_control_two, pin_control_one});
    assign sampled_channel = ccs_bits[4:0];

endmodule : adc_lowpower_and_control
`default_nettype wire

/* File: adc_ctrl_checker.sv */
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_checker #(
    parameter int RES_W = 10,
    parameter int PIN_N = 16
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic stop3_mode,
    input wire logic stop2_mode,
    input wire logic hw_trigger,
    input wire logic [RES_W-1:0] analog_sample,
    input wire logic at_ref_high,
    input wire logic at_ref_low,
    input wire logic conv_irq,
    input wire logic [PIN_N-1:0] pin_digital_disable,
    input wire logic [4:0] sampled_channel
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Tracks whether the asynchronous conversion clock is selected.
    logic async_sel;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            async_sel <= 1'b0;
        end else if (stop2_mode) begin
            async_sel <= 1'b0;
        end else if (reg_write && reg_addr == 4'h4) begin
            async_sel <= reg_wdata[1:0] == 2'h3;
        end
    end
    sequence s_cfg_write;
        reg_write && reg_addr == 4'h4 && !stop2_mode;
    endsequence
    sequence s_cfg_read;
        reg_read && reg_addr == 4'h4 && !reg_write && !stop2_mode;
    endsequence
    sequence s_abort;
        $rose(stop3_mode) && !async_sel;
    endsequence
    a_cfg_readback: assert property (s_cfg_write ##1 s_cfg_read |=> reg_rdata == $past(reg_wdata, 2))
        else $error("config readback differs from written value");
    a_ctl2_zero_bits: assert property (reg_read && reg_addr == 4'h1 |=> reg_rdata[3:2] == 2'h0)
        else $error("control2 bits 3:2 not zero");
    a_irq_matches_flag: assert property (reg_read && reg_addr == 4'h0 |=> (reg_rdata[7] && reg_rdata[6]) == $past(conv_irq))
        else $error("interrupt differs from flag and enable");
    a_stop2_clears_all: assert property (stop2_mode |=> pin_digital_disable == '0 && sampled_channel == 5'h1f && !conv_irq)
        else $error("stop2 left state set");
    a_pin_one_write: assert property (reg_write && reg_addr == 4'h7 && !stop2_mode |=> pin_digital_disable[7:0] == $past(reg_wdata))
        else $error("pin control one not applied");
    a_pin_two_write: assert property (reg_write && reg_addr == 4'h8 && !stop2_mode |=> pin_digital_disable[15:8] == $past(reg_wdata))
        else $error("pin control two not applied");
    a_channel_write: assert property (reg_write && reg_addr == 4'h0 && !stop2_mode |=> sampled_channel == $past(reg_wdata[4:0]))
        else $error("channel select not applied");
    a_abort_clears_active: assert property (s_abort ##[1:8] (stop3_mode && reg_read && reg_addr == 4'h1) |=> !reg_rdata[7])
        else $error("active flag set after abort");
endmodule : adc_ctrl_checker
bind adc_lowpower_and_control adc_ctrl_checker #(.RES_W(RES_W), .PIN_N(PIN_N)) i_checker (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .stop3_mode(stop3_mode), .stop2_mode(stop2_mode),
    .hw_trigger(hw_trigger), .analog_sample(analog_sample),
    .at_ref_high(at_ref_high), .at_ref_low(at_ref_low), .conv_irq(conv_irq),
    .pin_digital_disable(pin_digital_disable),
    .sampled_channel(sampled_channel));
`default_nettype wire

/* File: analog_source_model.sv */
// Analog input source that feeds the converter's sampled code.
`timescale 1ns/1ps
`default_nettype none
module analog_source_model (
    input wire logic core_clk,
    input wire logic [4:0] sampled_channel,
    input wire logic [11:0] level,
    output logic [9:0] analog_sample,
    output logic at_ref_high,
    output logic at_ref_low
);
    logic [9:0] idle_pattern = 10'h155;
    // An unselected input shows a moving pattern, never a held value.
    always @(posedge core_clk) idle_pattern <= ~idle_pattern;
    assign analog_sample = (sampled_channel == 5'h1f) ? idle_pattern : level[9:0];
    assign at_ref_high = level[10];
    assign at_ref_low = level[11];
endmodule : analog_source_model
`default_nettype wire

/* File: tb_adc_lowpower_and_control.sv */
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_lowpower_and_control;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic stop3_mode = 1'b0;
    logic stop2_mode = 1'b0;
    logic hw_trigger = 1'b0;
    logic [11:0] level = 12'h000;
    logic [7:0] reg_rdata;
    logic [9:0] analog_sample;
    logic at_ref_high;
    logic at_ref_low;
    logic conv_irq;
    logic [15:0] pin_digital_disable;
    logic [4:0] sampled_channel;
    logic [31:0] seed = 32'h2f12b74c;
    logic [7:0] d;
    logic [7:0] hi;
    logic [7:0] lo;
    int bad_count = 0;
    int checks = 0;
    int k;
    always #20 core_clk = ~core_clk;
    adc_lowpower_and_control i_dut (.core_clk(core_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .stop3_mode(stop3_mode),
        .stop2_mode(stop2_mode), .hw_trigger(hw_trigger),
        .analog_sample(analog_sample), .at_ref_high(at_ref_high),
        .at_ref_low(at_ref_low), .conv_irq(conv_irq),
        .pin_digital_disable(pin_digital_disable),
        .sampled_channel(sampled_channel));
    analog_source_model i_src (.core_clk(core_clk), .sampled_channel(sampled_channel),
        .level(level), .analog_sample(analog_sample),
        .at_ref_high(at_ref_high), .at_ref_low(at_ref_low));
    // ------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic conv(input logic [7:0] c1, input logic [11:0] lv);
        int n;
        level <= lv;
        wr(4'h0, c1);
        #1;
        for (n = 0; n < 6000 && conv_irq !== 1'b1; n++) @(posedge core_clk);
    endtask : conv
    task automatic rdres(input logic [15:0] e);
        rd(4'h2, hi);
        rd(4'h3, lo);
        chk("result", e, {hi, lo});
    endtask : rdres
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(4'h4, d); chk("config", 8'h00, d);
        rd(4'h1, d); chk("control2", 8'h00, d);
        rd(4'h0, d); chk("control1", 8'h1f, d);
        rd(4'hf, d); chk("unmapped", 8'h00, d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr <= 4'h4;
        reg_wdata <= 8'h98;
        @(posedge core_clk);
        reg_write <= 1'b0;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        chk("config", 8'h98, reg_rdata);
        for (k = 0; k < 4; k++) begin
            wr(4'h1, 8'h08 << k); rd(4'h1, d); chk("control2", (8'h08 << k) & 8'h70, d);
        end
        wr(4'h1, 8'h00);
        wr(4'h7, 8'h02);
        wr(4'h8, 8'h81);
        #1;
        chk("pins", 16'h8102, pin_digital_disable);
        $display("test registers done");
        for (k = 0; k < 4; k++) begin
            seed = xorshift(seed);
            wr(4'h4, k[0] ? 8'h18 : 8'h08);
            conv(8'h41, {2'b00, seed[9:0]}); chk("irq", 1, conv_irq);
            rdres(seed[9:0]);
        end
        conv(8'h41, 12'h400); rdres(16'h03ff);
        conv(8'h41, 12'h8ff); rdres(16'h0000);
        wr(4'h4, 8'h00); conv(8'h41, 12'h400); rdres(16'h00ff);
        $display("test conversions done");
        wr(4'h4, 8'h08); conv(8'h41, 12'h155); rd(4'h2, hi);
        conv(8'h41, 12'h2aa); rd(4'h3, lo); chk("locked", 16'h0155, {hi, lo});
        conv(8'h42, 12'h0c3); rdres(16'h00c3);
        wr(4'h4, 8'h18); wr(4'h0, 8'h43);
        rd(4'h1, d); chk("active", 1, d[7]);
        @(posedge core_clk); stop3_mode <= 1'b1;
        rd(4'h1, d); chk("active", 0, d[7]);
        rd(4'h0, d); chk("complete", 0, d[7]);
        rdres(16'h00c3);
        @(posedge core_clk); stop3_mode <= 1'b0;
        repeat (60) @(posedge core_clk);
        rd(4'h0, d); chk("idle", 0, d[7]);
        conv(8'h41, 12'h321); rdres(16'h0321);
        $display("test stop3 abort done");
        rd(4'h3, lo);
        wr(4'h4, 8'h0b); wr(4'h0, 8'h41);
        @(posedge core_clk); stop3_mode <= 1'b1;
        conv(8'h41, 12'h1e7); chk("irq", 1, conv_irq); rdres(16'h01e7);
        wr(4'h1, 8'h40); conv(8'h41, 12'h07e); chk("irq", 0, conv_irq);
        @(posedge core_clk); hw_trigger <= 1'b1;
        @(posedge core_clk); hw_trigger <= 1'b0;
        for (k = 0; k < 6000 && conv_irq !== 1'b1; k++) @(posedge core_clk);
        chk("irq", 1, conv_irq); rdres(16'h007e);
        wr(4'h1, 8'h00); conv(8'h61, 12'h2d2); rdres(16'h02d2);
        level <= 12'h1b4; repeat (3000) @(posedge core_clk);
        rdres(16'h01b4);
        wr(4'h0, 8'h41); stop3_mode <= 1'b0;
        $display("test stop3 async done");
        wr(4'h4, 8'h08); wr(4'h5, 8'h02);
        wr(4'h6, 8'h00); wr(4'h1, 8'h30);
        conv(8'h41, 12'h100); chk("irq", 0, conv_irq);
        conv(8'h41, 12'h300); chk("irq", 1, conv_irq); rdres(16'h0100);
        wr(4'h1, 8'h20); conv(8'h41, 12'h080); rdres(16'h0280);
        $display("test compare done");
        @(posedge core_clk); stop2_mode <= 1'b1;
        repeat (2) @(posedge core_clk); stop2_mode <= 1'b0;
        rd(4'h4, d); chk("config", 8'h00, d);
        rd(4'h1, d); chk("control2", 8'h00, d);
        rd(4'h0, d); chk("control1", 8'h1f, d);
        chk("pins", 16'h0000, pin_digital_disable);
        $display("test stop2 done");
        final_report();
    end
    initial begin
        #(40 * 90000);
        bad_count++;
        final_report();
    end
endmodule : tb_adc_lowpower_and_control
`default_nettype wire
